/* File: shared/pba_pkg.sv */
package pba_pkg;
  localparam int AD_W      = 32;
  localparam int CBE_W     = 4;
  localparam int CTL_W     = 5;
  localparam int BYTE_W    = 8;
  localparam int WORD_LSB  = 2;
  localparam int CMD_WR_BIT = 0;

  // bit positions inside the shared control vector (all active low on the bus)
  localparam int CTL_FRAME  = 0;
  localparam int CTL_IRDY   = 1;
  localparam int CTL_TRDY   = 2;
  localparam int CTL_STOP   = 3;
  localparam int CTL_DEVSEL = 4;

  localparam logic [3:0] CMD_IO_RD  = 4'h2;
  localparam logic [3:0] CMD_IO_WR  = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;

  localparam logic [31:0] IO_SUB_LIMIT  = 32'h0000_4000;
  localparam logic [31:0] MEM_SUB_LIMIT = 32'h0100_0000;

  // level of an undriven line (pull-ups)
  localparam logic [31:0] AD_PULL  = 32'hFFFF_FFFF;
  localparam logic [3:0]  CBE_PULL = 4'hF;
  localparam logic        PAR_PULL = 1'h1;

  localparam logic [2:0] SUB_DECODE_CYC   = 3'h3;
  localparam logic [2:0] MASTER_ABORT_CYC = 3'h5;
  localparam logic [2:0] CNT_ZERO         = 3'h0;
  localparam logic [2:0] CNT_ONE          = 3'h1;

  localparam logic [1:0] RSP_OK    = 2'h0;
  localparam logic [1:0] RSP_STOP  = 2'h1;
  localparam logic [1:0] RSP_ABORT = 2'h2;

  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_ADDR = 4'h2,
    M_DATA = 4'h4,
    M_TURN = 4'h8
  } pba_mst_t;

  typedef enum logic [3:0] {
    T_IDLE = 4'h1,
    T_DEC  = 4'h2,
    T_DATA = 4'h4,
    T_TURN = 4'h8
  } pba_tgt_t;

  function automatic logic par_even(input logic [AD_W-1:0] ad, input logic [CBE_W-1:0] cbe);
    return ^{ad, cbe};
  endfunction : par_even

  function automatic logic cmd_is_rd(input logic [CBE_W-1:0] cmd);
    return ~cmd[CMD_WR_BIT];
  endfunction : cmd_is_rd

  function automatic logic cmd_is_io(input logic [CBE_W-1:0] cmd);
    return (cmd == CMD_IO_RD) || (cmd == CMD_IO_WR);
  endfunction : cmd_is_io

  function automatic logic cmd_is_cfg(input logic [CBE_W-1:0] cmd);
    return (cmd == CMD_CFG_RD) || (cmd == CMD_CFG_WR);
  endfunction : cmd_is_cfg

  function automatic logic cmd_is_mem(input logic [CBE_W-1:0] cmd);
    return (cmd == CMD_MEM_RD) || (cmd == CMD_MEM_WR);
  endfunction : cmd_is_mem
endpackage : pba_pkg

/* File: shared/pba_bus_if.sv */
`timescale 1ns/1ps
interface pba_bus_if;
  import pba_pkg::*;

  logic [AD_W-1:0]  dev_ad;
  logic             dev_ad_oe;
  logic [CBE_W-1:0] dev_cbe;
  logic             dev_cbe_oe;
  logic             dev_par;
  logic             dev_par_oe;
  logic [CTL_W-1:0] dev_ctl;
  logic [CTL_W-1:0] dev_ctl_oe;

  logic [AD_W-1:0]  oth_ad;
  logic             oth_ad_oe;
  logic [CBE_W-1:0] oth_cbe;
  logic             oth_cbe_oe;
  logic             oth_par;
  logic             oth_par_oe;
  logic [CTL_W-1:0] oth_ctl;
  logic [CTL_W-1:0] oth_ctl_oe;

  logic [AD_W-1:0]  ad;
  logic [CBE_W-1:0] cbe;
  logic             par;
  logic [CTL_W-1:0] ctl_n;

  assign ad    = dev_ad_oe ? dev_ad : (oth_ad_oe ? oth_ad : AD_PULL);
  assign cbe   = dev_cbe_oe ? dev_cbe : (oth_cbe_oe ? oth_cbe : CBE_PULL);
  assign par   = dev_par_oe ? dev_par : (oth_par_oe ? oth_par : PAR_PULL);
  // control lines: pulled up, any driver may pull low
  assign ctl_n = (dev_ctl | ~dev_ctl_oe) & (oth_ctl | ~oth_ctl_oe);

  modport dev (
    output dev_ad, dev_ad_oe, dev_cbe, dev_cbe_oe, dev_par, dev_par_oe, dev_ctl, dev_ctl_oe,
    input  ad, cbe, par, ctl_n
  );

  modport oth (
    output oth_ad, oth_ad_oe, oth_cbe, oth_cbe_oe, oth_par, oth_par_oe, oth_ctl, oth_ctl_oe,
    input  ad, cbe, par, ctl_n
  );
endinterface : pba_bus_if

/* File: design/pba_dev_end.sv */
// Function
// - all timing from the bus clock input
// - command in address, byte enables in data
// - drive command lines only as master
// - address phase: drive as master, receive as target
// - memory target leaves data lines floating
// - cfg/io target drives reads, receives writes
// - drive even parity over data and command
// - never check or act on received parity
// - master frames access, target samples frame
// - read master ready only when accepting data
// - write master ready only with valid data
// - read target ready after data is driven
// - write target ready only when able to accept
// - initiator ready as master, target ready as target
// - master ends cycle after stop and releases
// - claim with device select, low ranges subtractively
`timescale 1ns/1ps
module pba_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] P_LAST = PW'(DEPTH - 1);
  localparam logic [PW-1:0] P_ONE  = PW'(1);
  localparam logic [CW-1:0] C_FULL = CW'(DEPTH);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [CW-1:0] cnt_ff;
  logic          push;
  logic          pop;

  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    return (p == P_LAST) ? '0 : p + P_ONE;
  endfunction : ptr_step

  assign in_ready  = (cnt_ff != C_FULL);
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wp_ff <= ptr_step(wp_ff);
      if (pop) rp_ff <= ptr_step(rp_ff);
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_ff[wp_ff] <= in_data;
  end
endmodule : pba_fifo

module pba_dev_end #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                               bus_clock_in,
  input  wire logic                               resetn,
  pba_bus_if.dev                                  bus,
  input  wire logic                               mreq_valid,
  output logic                                    mreq_ready,
  input  wire logic [pba_pkg::CBE_W-1:0]          mreq_cmd,
  input  wire logic [pba_pkg::AD_W-1:0]           mreq_addr,
  input  wire logic [pba_pkg::AD_W-1:0]           mreq_wdata,
  input  wire logic [pba_pkg::CBE_W-1:0]          mreq_be_n,
  output logic                                    mrsp_valid,
  output logic [1:0]                              mrsp_status,
  output logic [pba_pkg::AD_W-1:0]                mrsp_rdata,
  output logic                                    tgt_active,
  output logic [pba_pkg::CBE_W-1:0]               tgt_cmd,
  output logic [pba_pkg::AD_W-1:0]                tgt_addr,
  input  wire logic [pba_pkg::AD_W-1:0]           tgt_rdata,
  output logic                                    twr_valid,
  input  wire logic                               twr_ready,
  output logic [pba_pkg::AD_W+pba_pkg::CBE_W-1:0] twr_data
);
  import pba_pkg::*;

  pba_mst_t         m_st_ff;
  pba_mst_t         nxt_m_st;
  pba_tgt_t         t_st_ff;
  pba_tgt_t         nxt_t_st;
  logic [CBE_W-1:0] m_cmd_ff;
  logic [CBE_W-1:0] m_be_ff;
  logic [AD_W-1:0]  m_addr_ff;
  logic [AD_W-1:0]  m_wdata_ff;
  logic [2:0]       m_wait_ff;
  logic             mrsp_valid_ff;
  logic [1:0]       mrsp_status_ff;
  logic [AD_W-1:0]  mrsp_rdata_ff;
  logic [CBE_W-1:0] t_cmd_ff;
  logic [AD_W-1:0]  t_addr_ff;
  logic [AD_W-1:0]  t_rdata_ff;
  logic [2:0]       t_cnt_ff;
  logic             t_drv_ff;
  logic             frame_prev_ff;
  logic             par_ff;
  logic             par_oe_ff;

  logic frame_on, irdy_on, trdy_on, stop_on, devsel_on, bus_idle;
  logic m_idle, m_addr, m_data, m_turn, m_take, m_done, m_abort, m_end, m_wr;
  logic t_idle, t_dec, t_data, t_turn, t_start, t_sub_ok, t_claim, t_drop;
  logic t_rd_dp, t_mem_rd, t_wr, t_trdy, t_end, fifo_ready, push;

  assign frame_on  = ~bus.ctl_n[CTL_FRAME];
  assign irdy_on   = ~bus.ctl_n[CTL_IRDY];
  assign trdy_on   = ~bus.ctl_n[CTL_TRDY];
  assign stop_on   = ~bus.ctl_n[CTL_STOP];
  assign devsel_on = ~bus.ctl_n[CTL_DEVSEL];
  assign bus_idle  = ~frame_on & ~irdy_on;

  assign m_idle = (m_st_ff == M_IDLE);
  assign m_addr = (m_st_ff == M_ADDR);
  assign m_data = (m_st_ff == M_DATA);
  assign m_turn = (m_st_ff == M_TURN);
  assign m_wr   = ~cmd_is_rd(m_cmd_ff);
  assign t_idle = (t_st_ff == T_IDLE);
  assign t_dec  = (t_st_ff == T_DEC);
  assign t_data = (t_st_ff == T_DATA);
  assign t_turn = (t_st_ff == T_TURN);

  // master side: single data phase, own irdy always on in the data phase
  assign mreq_ready = m_idle & t_idle & bus_idle;
  assign m_take     = mreq_valid & mreq_ready;
  assign m_done     = m_data & (trdy_on | stop_on);
  assign m_abort    = m_data & ~devsel_on & (m_wait_ff == MASTER_ABORT_CYC);
  assign m_end      = m_done | m_abort;

  // target side: claim config at once, low io/memory subtractively
  assign t_start  = t_idle & m_idle & frame_on & ~frame_prev_ff;
  assign t_sub_ok = (cmd_is_io(t_cmd_ff) & (t_addr_ff < IO_SUB_LIMIT))
                  | (cmd_is_mem(t_cmd_ff) & (t_addr_ff < MEM_SUB_LIMIT));
  assign t_claim  = t_dec & (cmd_is_cfg(t_cmd_ff)
                  | (t_sub_ok & ~devsel_on & (t_cnt_ff == SUB_DECODE_CYC)));
  assign t_drop   = t_dec & ~t_claim & (devsel_on | (t_cnt_ff == SUB_DECODE_CYC));
  assign t_rd_dp  = t_data & cmd_is_rd(t_cmd_ff) & ~cmd_is_mem(t_cmd_ff);
  assign t_mem_rd = t_data & (t_cmd_ff == CMD_MEM_RD);
  assign t_wr     = t_data & ~cmd_is_rd(t_cmd_ff);
  assign t_trdy   = (t_rd_dp & t_drv_ff)
                  | (t_wr & fifo_ready);
  assign t_end    = t_data & ((irdy_on & (trdy_on | stop_on)) | bus_idle);
  assign push     = t_wr & irdy_on & t_trdy;

  // address/data and command drive by role and phase
  assign bus.dev_ad     = m_addr ? m_addr_ff : (m_data ? m_wdata_ff : t_rdata_ff);
  assign bus.dev_ad_oe  = m_addr | (m_data & m_wr) | t_rd_dp;
  assign bus.dev_cbe    = m_addr ? m_cmd_ff : m_be_ff;
  assign bus.dev_cbe_oe = m_addr | m_data;
  assign bus.dev_par    = par_ff;
  assign bus.dev_par_oe = par_oe_ff;

  // turnaround states drive the lines high for one cycle before release
  assign bus.dev_ctl[CTL_FRAME]     = ~m_addr;
  assign bus.dev_ctl[CTL_IRDY]      = ~m_data;
  assign bus.dev_ctl[CTL_TRDY]      = ~t_trdy;
  assign bus.dev_ctl[CTL_STOP]      = ~t_mem_rd;
  assign bus.dev_ctl[CTL_DEVSEL]    = ~t_data;
  assign bus.dev_ctl_oe[CTL_FRAME]  = m_addr | m_data | m_turn;
  assign bus.dev_ctl_oe[CTL_IRDY]   = m_addr | m_data | m_turn;
  assign bus.dev_ctl_oe[CTL_TRDY]   = t_data | t_turn;
  assign bus.dev_ctl_oe[CTL_STOP]   = t_data | t_turn;
  assign bus.dev_ctl_oe[CTL_DEVSEL] = t_data | t_turn;

  assign mrsp_valid  = mrsp_valid_ff;
  assign mrsp_status = mrsp_status_ff;
  assign mrsp_rdata  = mrsp_rdata_ff;
  assign tgt_active  = ~t_idle;
  assign tgt_cmd     = t_cmd_ff;
  assign tgt_addr    = t_addr_ff;

  pba_fifo #(
    .W     (AD_W + CBE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (bus_clock_in),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({bus.cbe, bus.ad}),
    .out_valid (twr_valid),
    .out_ready (twr_ready),
    .out_data  (twr_data)
  );

  always_comb begin
    nxt_m_st = m_st_ff;
    case (m_st_ff)
      M_IDLE: if (m_take) nxt_m_st = M_ADDR;
      M_ADDR: nxt_m_st = M_DATA;
      M_DATA: if (m_end) nxt_m_st = M_TURN;
      M_TURN: nxt_m_st = M_IDLE;
      default: nxt_m_st = M_IDLE;
    endcase
  end

  always_comb begin
    nxt_t_st = t_st_ff;
    case (t_st_ff)
      T_IDLE: if (t_start) nxt_t_st = T_DEC;
      T_DEC: begin
        if (t_claim) nxt_t_st = T_DATA;
        else if (t_drop) nxt_t_st = T_IDLE;
      end
      T_DATA: if (t_end) nxt_t_st = T_TURN;
      T_TURN: nxt_t_st = T_IDLE;
      default: nxt_t_st = T_IDLE;
    endcase
  end

  always_ff @(posedge bus_clock_in or negedge resetn) begin
    if (!resetn) begin
      m_st_ff       <= M_IDLE;
      t_st_ff       <= T_IDLE;
      m_wait_ff     <= CNT_ZERO;
      t_cnt_ff      <= CNT_ZERO;
      t_drv_ff      <= 1'h0;
      frame_prev_ff <= 1'h0;
      mrsp_valid_ff <= 1'h0;
    end else begin
      m_st_ff       <= nxt_m_st;
      t_st_ff       <= nxt_t_st;
      m_wait_ff     <= m_data ? m_wait_ff + CNT_ONE : CNT_ZERO;
      t_cnt_ff      <= t_dec ? t_cnt_ff + CNT_ONE : CNT_ZERO;
      t_drv_ff      <= t_rd_dp;
      frame_prev_ff <= frame_on;
      mrsp_valid_ff <= m_end;
    end
  end

  always_ff @(posedge bus_clock_in or negedge resetn) begin
    if (!resetn) begin
      m_cmd_ff       <= CMD_MEM_RD;
      m_be_ff        <= CBE_PULL;
      m_addr_ff      <= '0;
      m_wdata_ff     <= '0;
      mrsp_status_ff <= RSP_OK;
      mrsp_rdata_ff  <= '0;
      t_cmd_ff       <= CMD_MEM_RD;
      t_addr_ff      <= '0;
      t_rdata_ff     <= '0;
    end else begin
      if (m_take) begin
        m_cmd_ff   <= mreq_cmd;
        m_addr_ff  <= mreq_addr;
        m_wdata_ff <= mreq_wdata;
        m_be_ff    <= mreq_be_n;
      end
      if (m_end) begin
        mrsp_status_ff <= trdy_on ? RSP_OK : (stop_on ? RSP_STOP : RSP_ABORT);
        mrsp_rdata_ff  <= bus.ad;
      end
      if (t_start) begin
        t_cmd_ff  <= bus.cbe;
        t_addr_ff <= bus.ad;
      end
      if (t_claim) t_rdata_ff <= tgt_rdata;
    end
  end

  // parity trails the driven address/data by one clock; received parity unused
  always_ff @(posedge bus_clock_in or negedge resetn) begin
    if (!resetn) begin
      par_ff    <= PAR_PULL;
      par_oe_ff <= 1'h0;
    end else begin
      par_ff    <= par_even(bus.ad, bus.cbe);
      par_oe_ff <= bus.dev_ad_oe;
    end
  end
endmodule : pba_dev_end

/* File: design/pba_oth_end.sv */
`timescale 1ns/1ps
module pba_oth_end #(
  parameter logic [31:0] WIN_BASE  = 32'h4000_0000,
  parameter logic [31:0] WIN_MASK  = 32'hFFFF_FFC0,
  parameter int          MEM_WORDS = 16
) (
  input  wire logic                      bus_clock_in,
  input  wire logic                      resetn,
  pba_bus_if.oth                         bus,
  input  wire logic                      oreq_valid,
  output logic                           oreq_ready,
  input  wire logic [pba_pkg::CBE_W-1:0] oreq_cmd,
  input  wire logic [pba_pkg::AD_W-1:0]  oreq_addr,
  input  wire logic [pba_pkg::AD_W-1:0]  oreq_wdata,
  input  wire logic [pba_pkg::CBE_W-1:0] oreq_be_n,
  input  wire logic                      orsp_ready,
  output logic                           orsp_valid,
  output logic [1:0]                     orsp_status,
  output logic [pba_pkg::AD_W-1:0]       orsp_rdata
);
  import pba_pkg::*;
  localparam int IXW = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;

  pba_mst_t         m_st_ff;
  pba_mst_t         nxt_m_st;
  pba_tgt_t         t_st_ff;
  pba_tgt_t         nxt_t_st;
  logic [CBE_W-1:0] m_cmd_ff;
  logic [CBE_W-1:0] m_be_ff;
  logic [AD_W-1:0]  m_addr_ff;
  logic [AD_W-1:0]  m_wdata_ff;
  logic [2:0]       m_wait_ff;
  logic             m_wdrv_ff;
  logic             orsp_valid_ff;
  logic [1:0]       orsp_status_ff;
  logic [AD_W-1:0]  orsp_rdata_ff;
  logic [CBE_W-1:0] t_cmd_ff;
  logic [IXW-1:0]   t_ix_ff;
  logic [AD_W-1:0]  t_rdata_ff;
  logic             t_drv_ff;
  logic             frame_prev_ff;
  logic             par_ff;
  logic             par_oe_ff;
  logic [AD_W-1:0]  mem_ff [MEM_WORDS];

  logic frame_on, irdy_on, trdy_on, stop_on, devsel_on, bus_idle;
  logic m_addr, m_data, m_turn, m_wr, m_irdy, m_take, m_end, m_abort;
  logic t_idle, t_data, t_turn, t_start, t_rd, t_trdy, t_end, t_push;

  assign frame_on  = ~bus.ctl_n[CTL_FRAME];
  assign irdy_on   = ~bus.ctl_n[CTL_IRDY];
  assign trdy_on   = ~bus.ctl_n[CTL_TRDY];
  assign stop_on   = ~bus.ctl_n[CTL_STOP];
  assign devsel_on = ~bus.ctl_n[CTL_DEVSEL];
  assign bus_idle  = ~frame_on & ~irdy_on;

  assign m_addr = (m_st_ff == M_ADDR);
  assign m_data = (m_st_ff == M_DATA);
  assign m_turn = (m_st_ff == M_TURN);
  assign m_wr   = ~cmd_is_rd(m_cmd_ff);
  assign t_idle = (t_st_ff == T_IDLE);
  assign t_data = (t_st_ff == T_DATA);
  assign t_turn = (t_st_ff == T_TURN);

  assign oreq_ready = (m_st_ff == M_IDLE) & t_idle & bus_idle;
  assign m_take     = oreq_valid & oreq_ready;
  // read: ready only while the response can be taken; write: a cycle after data
  assign m_irdy     = m_data & (m_wr ? m_wdrv_ff : orsp_ready);
  assign m_abort    = m_data & ~devsel_on & (m_wait_ff == MASTER_ABORT_CYC);
  assign m_end      = (m_irdy & (trdy_on | stop_on)) | m_abort;

  // fast positive decode of a memory window
  assign t_start = t_idle & (m_st_ff == M_IDLE) & frame_on & ~frame_prev_ff
                 & cmd_is_mem(bus.cbe) & ((bus.ad & WIN_MASK) == WIN_BASE);
  assign t_rd    = t_data & cmd_is_rd(t_cmd_ff);
  assign t_trdy  = t_data & (~t_rd | t_drv_ff);
  assign t_end   = t_data & ((irdy_on & trdy_on) | bus_idle);
  assign t_push  = t_data & ~t_rd & irdy_on & trdy_on;

  assign bus.oth_ad     = m_addr ? m_addr_ff : (m_data ? m_wdata_ff : t_rdata_ff);
  assign bus.oth_ad_oe  = m_addr | (m_data & m_wr) | t_rd;
  assign bus.oth_cbe    = m_addr ? m_cmd_ff : m_be_ff;
  assign bus.oth_cbe_oe = m_addr | m_data;
  assign bus.oth_par    = par_ff;
  assign bus.oth_par_oe = par_oe_ff;

  // frame stays low through a data phase until irdy, so a stalled access never looks idle
  assign bus.oth_ctl[CTL_FRAME]     = ~(m_addr | (m_data & ~m_irdy));
  assign bus.oth_ctl[CTL_IRDY]      = ~m_irdy;
  assign bus.oth_ctl[CTL_TRDY]      = ~t_trdy;
  assign bus.oth_ctl[CTL_STOP]      = 1'h1;
  assign bus.oth_ctl[CTL_DEVSEL]    = ~t_data;
  assign bus.oth_ctl_oe[CTL_FRAME]  = m_addr | m_data | m_turn;
  assign bus.oth_ctl_oe[CTL_IRDY]   = m_addr | m_data | m_turn;
  assign bus.oth_ctl_oe[CTL_TRDY]   = t_data | t_turn;
  assign bus.oth_ctl_oe[CTL_STOP]   = t_data | t_turn;
  assign bus.oth_ctl_oe[CTL_DEVSEL] = t_data | t_turn;

  assign orsp_valid  = orsp_valid_ff;
  assign orsp_status = orsp_status_ff;
  assign orsp_rdata  = orsp_rdata_ff;

  always_comb begin
    nxt_m_st = m_st_ff;
    case (m_st_ff)
      M_IDLE: if (m_take) nxt_m_st = M_ADDR;
      M_ADDR: nxt_m_st = M_DATA;
      M_DATA: if (m_end) nxt_m_st = M_TURN;
      M_TURN: nxt_m_st = M_IDLE;
      default: nxt_m_st = M_IDLE;
    endcase
  end

  always_comb begin
    nxt_t_st = t_st_ff;
    case (t_st_ff)
      T_IDLE: if (t_start) nxt_t_st = T_DATA;
      T_DATA: if (t_end) nxt_t_st = T_TURN;
      T_TURN: nxt_t_st = T_IDLE;
      default: nxt_t_st = T_IDLE;
    endcase
  end

  always_ff @(posedge bus_clock_in or negedge resetn) begin
    if (!resetn) begin
      m_st_ff        <= M_IDLE;
      t_st_ff        <= T_IDLE;
      m_wait_ff      <= CNT_ZERO;
      m_wdrv_ff      <= 1'h0;
      t_drv_ff       <= 1'h0;
      frame_prev_ff  <= 1'h0;
      orsp_valid_ff  <= 1'h0;
      orsp_status_ff <= RSP_OK;
      orsp_rdata_ff  <= '0;
      m_cmd_ff       <= CMD_MEM_RD;
      m_be_ff        <= CBE_PULL;
      m_addr_ff      <= '0;
      m_wdata_ff     <= '0;
      t_cmd_ff       <= CMD_MEM_RD;
      t_ix_ff        <= '0;
      t_rdata_ff     <= '0;
      par_ff         <= PAR_PULL;
      par_oe_ff      <= 1'h0;
    end else begin
      m_st_ff       <= nxt_m_st;
      t_st_ff       <= nxt_t_st;
      m_wait_ff     <= m_data ? m_wait_ff + CNT_ONE : CNT_ZERO;
      m_wdrv_ff     <= m_data & m_wr;
      t_drv_ff      <= t_rd;
      frame_prev_ff <= frame_on;
      orsp_valid_ff <= m_end;
      par_ff        <= par_even(bus.ad, bus.cbe);
      par_oe_ff     <= bus.oth_ad_oe;
      if (m_take) begin
        m_cmd_ff   <= oreq_cmd;
        m_addr_ff  <= oreq_addr;
        m_wdata_ff <= oreq_wdata;
        m_be_ff    <= oreq_be_n;
      end
      if (m_end) begin
        orsp_status_ff <= trdy_on ? RSP_OK : (stop_on ? RSP_STOP : RSP_ABORT);
        orsp_rdata_ff  <= bus.ad;
      end
      if (t_start) begin
        t_cmd_ff   <= bus.cbe;
        t_ix_ff    <= bus.ad[WORD_LSB +: IXW];
        t_rdata_ff <= mem_ff[bus.ad[WORD_LSB +: IXW]];
      end
    end
  end

  always_ff @(posedge bus_clock_in) begin
    for (int i = 0; i < CBE_W; i++) begin
      if (t_push && !bus.cbe[i]) mem_ff[t_ix_ff][i*BYTE_W +: BYTE_W] <= bus.ad[i*BYTE_W +: BYTE_W];
    end
  end
endmodule : pba_oth_end

/* File: testbench/pba_bus_sva.sv */
`timescale 1ns/1ps
module pba_bus_sva import pba_pkg::*; (
  input wire logic        bus_clock_in,
  input wire logic        resetn,
  input wire logic        dev_ad_oe,
  input wire logic        dev_cbe_oe,
  input wire logic        dev_par,
  input wire logic        dev_par_oe,
  input wire logic [4:0]  dev_ctl,
  input wire logic [4:0]  dev_ctl_oe,
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe,
  input wire logic [4:0]  ctl_n
);
  default clocking cb @(posedge bus_clock_in); endclocking
  default disable iff (!resetn);
  logic [3:0] tcmd_ff;
  logic       frm_ff;
  // address phase of the other agent: frame falls while this end does not drive it
  wire o_adr  = !ctl_n[CTL_FRAME] && !dev_ctl_oe[CTL_FRAME] && !frm_ff;
  wire m_irdy = dev_ctl_oe[CTL_IRDY] && !dev_ctl[CTL_IRDY];
  wire t_sel  = dev_ctl_oe[CTL_DEVSEL] && !dev_ctl[CTL_DEVSEL];
  wire t_rd   = tcmd_ff == CMD_CFG_RD || tcmd_ff == CMD_IO_RD;
  wire t_flt  = tcmd_ff[CMD_WR_BIT] || tcmd_ff == CMD_MEM_RD;
  // command of the last address phase started by the other agent
  always_ff @(posedge bus_clock_in or negedge resetn) begin
    if (!resetn) begin
      tcmd_ff <= 4'hF;
      frm_ff  <= 1'h0;
    end else begin
      frm_ff <= !ctl_n[CTL_FRAME];
      if (o_adr) tcmd_ff <= cbe;
    end
  end
  par_even_a: assert property (dev_par_oe |-> dev_par == ^{$past(ad), $past(cbe)})
    else $error("parity not even");
  cbe_drive_a: assert property (dev_cbe_oe |-> !dev_ctl_oe[CTL_TRDY] && !dev_ctl_oe[CTL_DEVSEL])
    else $error("cbe driven as target");
  addr_drive_a: assert property (dev_ctl_oe[CTL_FRAME] && !dev_ctl[CTL_FRAME] |-> dev_ad_oe && dev_cbe_oe)
    else $error("master address not driven");
  addr_recv_a: assert property (o_adr |-> !dev_ad_oe && !dev_cbe_oe ##1 !dev_ad_oe)
    else $error("target drove address phase");
  mem_float_a: assert property (t_sel && t_flt |-> !dev_ad_oe)
    else $error("target drove ad");
  rd_data_a: assert property (t_rd && dev_ctl_oe[CTL_TRDY] && !dev_ctl[CTL_TRDY] |-> dev_ad_oe && $past(dev_ad_oe))
    else $error("trdy before read data");
  cfg_claim_a: assert property (o_adr && (cbe == CMD_CFG_RD || cbe == CMD_CFG_WR) |-> ##[1:2] t_sel)
    else $error("cfg cycle not claimed");
  wait_hold_a: assert property (m_irdy && !ctl_n[CTL_DEVSEL] && ctl_n[CTL_TRDY] && ctl_n[CTL_STOP]
    |=> m_irdy && $stable(cbe))
    else $error("wait state not held");
endmodule : pba_bus_sva

/* File: testbench/pba_bus_agent_interface_tb.sv */
`timescale 1ns/1ps
module pba_bus_agent_interface_tb;
  import pba_pkg::*;
  logic        clk = 1'b0, resetn = 1'b0, mv = 1'b0, ov = 1'b0, ordy = 1'b1, twr_rdy = 1'b0;
  logic [3:0]  cmd = 4'h0, be_n = 4'h0, tcmd;
  logic [31:0] adr = 32'h0, wd = 32'h0, trd = 32'h5A5A_1234, mrd, ord, tadr;
  logic        mrdy, mval, ordy_o, oval, tact, twv;
  logic [1:0]  mst, ost;
  logic [35:0] twd;
  logic [3:0]  wc [5] = '{CMD_CFG_WR, CMD_IO_WR, CMD_MEM_WR, CMD_CFG_WR, CMD_MEM_WR};
  logic [31:0] wa [5] = '{32'h0000_0010, 32'h0000_0100, 32'h0000_1000, 32'h0000_0014, 32'h0000_2000};
  int          n_errors = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  pba_bus_if bus_if ();
  pba_dev_end u_pba_dev_end (.bus_clock_in(clk), .resetn(resetn), .bus(bus_if), .mreq_valid(mv),
    .mreq_ready(mrdy), .mreq_cmd(cmd), .mreq_addr(adr), .mreq_wdata(wd), .mreq_be_n(be_n), .mrsp_valid(mval),
    .mrsp_status(mst), .mrsp_rdata(mrd), .tgt_active(tact), .tgt_cmd(tcmd), .tgt_addr(tadr), .tgt_rdata(trd),
    .twr_valid(twv), .twr_ready(twr_rdy), .twr_data(twd));
  pba_oth_end u_pba_oth_end (.bus_clock_in(clk), .resetn(resetn), .bus(bus_if), .oreq_valid(ov),
    .oreq_ready(ordy_o), .oreq_cmd(cmd), .oreq_addr(adr), .oreq_wdata(wd), .oreq_be_n(be_n), .orsp_ready(ordy),
    .orsp_valid(oval), .orsp_status(ost), .orsp_rdata(ord));
  pba_bus_sva u_pba_bus_sva (.bus_clock_in(clk), .resetn(resetn), .dev_ad_oe(bus_if.dev_ad_oe),
    .dev_cbe_oe(bus_if.dev_cbe_oe), .dev_par(bus_if.dev_par), .dev_par_oe(bus_if.dev_par_oe),
    .dev_ctl(bus_if.dev_ctl), .dev_ctl_oe(bus_if.dev_ctl_oe), .ad(bus_if.ad), .cbe(bus_if.cbe), .ctl_n(bus_if.ctl_n));
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  function automatic logic pick(input int s);
    case (s)
      0: return mrdy;
      1: return mval;
      2: return ordy_o;
      3: return oval;
      default: return twv;
    endcase
  endfunction : pick
  task automatic wait_for(input int s);
    int n;
    n = 0;
    while (pick(s) !== 1'b1 && n < 40) begin
      @(posedge clk) #1;
      n++;
    end
    chk(n < 40, 1'b1);
  endtask : wait_for
  // request from the device end (o=0) or the other end (o=1)
  task automatic op(input bit o, input logic [3:0] c, input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] b);
    {cmd, adr, wd, be_n} = {c, a, d, b};
    if (o) ov = 1'b1;
    else mv = 1'b1;
    wait_for(o ? 2 : 0);
    @(posedge clk) #1;
    {mv, ov} = 2'h0;
  endtask : op
  task automatic rsp(input bit o, input logic [1:0] s, input logic [31:0] r, input bit cr);
    wait_for(o ? 3 : 1);
    chk(o ? ost : mst, s);
    if (cr) chk(o ? ord : mrd, r);
    @(posedge clk) #1;
  endtask : rsp
  task automatic results;
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    op(0, CMD_MEM_WR, 32'h4000_0008, 32'hA5C3_0F11, 4'h0);
    rsp(0, RSP_OK, 32'h0, 0);
    op(0, CMD_MEM_RD, 32'h4000_0008, 32'h0, 4'h0);
    rsp(0, RSP_OK, 32'hA5C3_0F11, 1);
    op(0, CMD_MEM_RD, 32'h8000_0000, 32'h0, 4'h0);
    rsp(0, RSP_ABORT, 32'h0, 0);
    for (int i = 0; i < 5; i++) begin
      op(1, wc[i], wa[i], 32'h1111_0000 + 32'(i), 4'(i));
      if (i < 4) rsp(1, RSP_OK, 32'h0, 0);
    end
    // fifo full: the fifth write must wait
    repeat (20) begin
      @(posedge clk) #1;
      chk({oval, twv}, 2'h1);
    end
    twr_rdy = 1'b1;
    fork
      rsp(1, RSP_OK, 32'h0, 0);
      for (int i = 0; i < 5; i++) begin
        wait_for(4);
        chk(twd, {4'(i), 32'h1111_0000 + 32'(i)});
        @(posedge clk) #1;
      end
    join
    chk(twv, 1'b0);
    ordy = 1'b0;
    op(1, CMD_CFG_RD, 32'h0000_0020, 32'h0, 4'h0);
    repeat (6) @(posedge clk) #1;
    chk({tact, tcmd, oval}, {1'b1, CMD_CFG_RD, 1'b0});
    chk(tadr, 32'h0000_0020);
    ordy = 1'b1;
    rsp(1, RSP_OK, trd, 1);
    op(1, CMD_IO_RD, 32'h0000_0300, 32'h0, 4'h0);
    rsp(1, RSP_OK, trd, 1);
    op(1, CMD_MEM_RD, 32'h0000_3000, 32'h0, 4'h0);
    rsp(1, RSP_STOP, 32'h0, 0);
    results();
  end
  initial begin
    #20000;
    n_errors++;
    results();
  end
endmodule : pba_bus_agent_interface_tb
